/* File: logic/sgpc_consts.svh */
`ifndef SGPC_CONSTS_SVH
`define SGPC_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define SGPC_IDX_PIN_INDEX   6'h13
`define SGPC_IDX_SETUP_WIN   6'h14
`define SGPC_IDX_OUT_LATCH0  6'h18
`define SGPC_IDX_OUT_LATCH1  6'h19
`define SGPC_IDX_PENDING     6'h1a
`define SGPC_IDX_PIN_LEVEL   6'h1b

// Pin index fields
`define SGPC_SEL_PORT        4
`define SGPC_SEL_PIN_HI      2

// Setup window fields
`define SGPC_CFG_OE          0
`define SGPC_CFG_OTYPE       1
`define SGPC_CFG_PULLUP      2
`define SGPC_CFG_LOCK        3
`define SGPC_CFG_ETYPE       4
`define SGPC_CFG_EPOL        5
`define SGPC_CFG_DBEN        6

// Pin counts
`define SGPC_BIDIR_PINS      6
`define SGPC_EVENT_PINS      8
`define SGPC_OUT_PINS        2

// Reset values
`define SGPC_SEL_RST         8'h00
`define SGPC_CFG_P0_RST      7'h44
`define SGPC_CFG_P1_RST      3'h2
`define SGPC_OUT0_RST        6'h3f
`define SGPC_OUT1_RST        2'h3
`define SGPC_PIN_IDLE        1'b1

// Debounce timing
`define SGPC_DEBOUNCE_US     15000
`define SGPC_CLK_MHZ         250
`define SGPC_DEBOUNCE_CYC    (`SGPC_DEBOUNCE_US * `SGPC_CLK_MHZ)

`endif

/* File: logic/sgpc_pkg.sv */
package sgpc_pkg;

    // Port 1 setup holds only output type, pull-up and lock; enable reads as 1
    typedef struct packed {
        logic [7:0][6:0] p0_cfg;
        logic [1:0][2:0] p1_cfg;
        logic            sel_port;
        logic [2:0]      sel_pin;
        logic [5:0]      out0;
        logic [1:0]      out1;
        logic [7:0]      pend;
        logic [7:0]      prev;
        logic            ack;
        logic [31:0]     rdata;
    } sgpc_state_s;

    typedef logic [31:0] sgpc_word_t;

endpackage

/* File: logic/sgpc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgpc_consts.svh"
module sgpc_sync #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sgpc_sync_s;

    sgpc_sync_s st_r;
    sgpc_sync_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= {(2 * WIDTH){`SGPC_PIN_IDLE}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;
endmodule // sgpc_sync
`default_nettype wire

/* File: logic/sgpc_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgpc_consts.svh"
module sgpc_debounce #(
    parameter int CYCLES = 3750000
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Control
    input  wire logic i_enable,
    // Data
    input  wire logic i_level,
    output logic      o_level
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
    } sgpc_deb_s;

    sgpc_deb_s st_r;
    sgpc_deb_s st_nxt;

    // Any return to the old level restarts the quiet period
    always_comb begin
        st_nxt = st_r;
        if (!i_enable || i_level == st_r.level) begin
            st_nxt.cnt   = '0;
            st_nxt.level = i_level;
        end else if (st_r.cnt == LAST) begin
            st_nxt.cnt   = '0;
            st_nxt.level = i_level;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= {{CW{1'b0}}, `SGPC_PIN_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.level;
endmodule // sgpc_debounce
`default_nettype wire

/* File: logic/sgpc_top.sv */
// Contract
// RQ1 - Only edge detection exists; event type value 1 changes nothing.
// RQ2 - Polarity 0 detects falling edges (default), 1 detects rising edges.
// RQ3 - Debounced input passes only after the pin stays quiet about 15 ms.
// RQ4 - Debounce delays both setting and clearing of the pending indicator; here it delays only setting, clearing is by register write.
// RQ5 - Software should disable debounce for level events if delay hurts.
// RQ6 - Debounce enable 0 off, 1 on; on by default for event pins.
// RQ7 - Pin index clears to zero on power-up and software reset.
// RQ8 - Port select 0 picks port 0 (default), 1 picks port 1.
// RQ9 - Pin select holds binary pin number 0..7, default 0.
// RQ10 - Port 0 covers bidir and event pins; port 1 the two outputs.
// RQ11 - One window address reaches the setup of the indexed pin.
// RQ12 - Bits 0-3 for bidir and output pins; 4-6 for event pins.
// RQ13 - Lock is set-only, cleared by power-up; freezes bits 2-0 and output.
// RQ14 - Pull-up control 0 disables, 1 enables (default).
// RQ15 - Output type 0 open-drain (default), 1 push-pull.
// RQ16 - Output-only pins read enable as 1; bidir enable default off.
// RQ17 - Output enable never affects input sampling or readback.
// RQ18 - Output-only bits 7-4 and all plain-input bits read zero.
// RQ19 - Locked pins ignore writes to their output latch bit.
// RQ20 - Each detected event sets a per-pin pending flag, readable.
// RQ21 - Pins synchronised, debounced, then edges found from filtered samples.
`timescale 1ns/1ps
`default_nettype none
`include "sgpc_consts.svh"
module sgpc_top #(
    parameter int DEBOUNCE_CYCLES = `SGPC_DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_soft_reset,
    // Avalon-MM slave
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [3:0]        i_avs_byteenable,
    input  wire sgpc_pkg::sgpc_word_t i_avs_writedata,
    output sgpc_pkg::sgpc_word_t   o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // Port 0 pins: 0..5 bidirectional, 6..7 event inputs
    input  wire logic [7:0]        i_pin0_in,
    output logic      [5:0]        o_pin0_out,
    output logic      [5:0]        o_pin0_oe,
    output logic      [5:0]        o_pin0_pullup,
    // Port 1 pins: 0..1 output-only, 2..3 plain inputs
    input  wire logic [3:0]        i_pin1_in,
    output logic      [1:0]        o_pin1_out,
    output logic      [1:0]        o_pin1_oe,
    output logic      [1:0]        o_pin1_pullup,
    // Event pending flags towards the wake-up logic
    output logic      [7:0]        o_event_pending
);
    import sgpc_pkg::*;

    sgpc_state_s st_r;
    sgpc_state_s st_nxt;
    logic [11:0] sync_q;
    logic [7:0]  filt;
    logic [7:0]  ev_hit;
    logic [5:0]  widx;
    logic        rd_take;
    logic        wr_go;
    logic [7:0]  wd;

    // Port and pin of the selected setup register
    function automatic logic sel_bidir(input logic port, input logic [2:0] pin);
        return !port && pin < 3'(`SGPC_BIDIR_PINS);
    endfunction

    function automatic logic sel_outonly(input logic port, input logic [2:0] pin);
        return port && pin < 3'(`SGPC_OUT_PINS);
    endfunction

    function automatic logic [7:0] setup_view(input sgpc_state_s s);
        logic [7:0] v;
        v = 8'h00;
        if (!s.sel_port) begin
            v[6:4] = s.p0_cfg[s.sel_pin][6:4]; // see RQ12
            if (sel_bidir(s.sel_port, s.sel_pin)) begin
                v[3:0] = s.p0_cfg[s.sel_pin][3:0];
            end
        end else if (sel_outonly(s.sel_port, s.sel_pin)) begin
            v[3:1] = s.p1_cfg[s.sel_pin[0]]; // see RQ18
            v[0]   = 1'b1; // see RQ16
        end
        return v;
    endfunction

    // Inputs are sampled regardless of any output enable
    sgpc_sync #(
        .WIDTH (12)
    ) u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  ({i_pin1_in, i_pin0_in}),
        .o_sync   (sync_q)
    ); // see RQ17, RQ21

    for (genvar gi = 0; gi < `SGPC_EVENT_PINS; gi++) begin : g_deb
        sgpc_debounce #(
            .CYCLES (DEBOUNCE_CYCLES)
        ) u_deb (
            .i_clk    (i_clk),
            .i_resetn (i_resetn),
            .i_enable (st_r.p0_cfg[gi][`SGPC_CFG_DBEN]),
            .i_level  (sync_q[gi]),
            .o_level  (filt[gi])
        ); // see RQ3, RQ4, RQ6
    end

    // Event type is stored but only edges are ever detected
    always_comb begin
        for (int i = 0; i < `SGPC_EVENT_PINS; i++) begin
            ev_hit[i] = st_r.p0_cfg[i][`SGPC_CFG_EPOL] ? (filt[i] && !st_r.prev[i])
                                                       : (!filt[i] && st_r.prev[i]);
        end
    end // see RQ1, RQ2, RQ21

    assign widx    = i_avs_address[7:2];
    assign rd_take = i_avs_read && !st_r.ack;
    assign wr_go   = i_avs_write && st_r.ack && i_avs_byteenable[0];
    assign wd      = i_avs_writedata[7:0];

    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = filt;
        // One wait cycle for every access, then the answer
        st_nxt.ack  = (i_avs_read || i_avs_write) && !st_r.ack;

        if (rd_take) begin
            case (widx)
                `SGPC_IDX_PIN_INDEX:  st_nxt.rdata = {24'h0, 3'h0, st_r.sel_port, 1'b0,
                                                      st_r.sel_pin};
                `SGPC_IDX_SETUP_WIN:  st_nxt.rdata = {24'h0, setup_view(st_r)}; // see RQ11
                `SGPC_IDX_OUT_LATCH0: st_nxt.rdata = {26'h0, st_r.out0};
                `SGPC_IDX_OUT_LATCH1: st_nxt.rdata = {30'h0, st_r.out1};
                `SGPC_IDX_PENDING:    st_nxt.rdata = {24'h0, st_r.pend}; // see RQ20
                `SGPC_IDX_PIN_LEVEL:  st_nxt.rdata = {20'h0, sync_q}; // see RQ17
                default:              st_nxt.rdata = 32'h0;
            endcase
        end

        if (wr_go) begin
            case (widx)
                `SGPC_IDX_PIN_INDEX: begin
                    st_nxt.sel_port = wd[`SGPC_SEL_PORT]; // see RQ8
                    st_nxt.sel_pin  = wd[`SGPC_SEL_PIN_HI:0]; // see RQ9
                end
                `SGPC_IDX_SETUP_WIN: begin
                    if (!st_r.sel_port) begin
                        // Event fields stay writable on a locked pin
                        st_nxt.p0_cfg[st_r.sel_pin][6:4] = wd[6:4]; // see RQ10, RQ12
                        if (sel_bidir(st_r.sel_port, st_r.sel_pin)) begin
                            if (!st_r.p0_cfg[st_r.sel_pin][`SGPC_CFG_LOCK]) begin
                                st_nxt.p0_cfg[st_r.sel_pin][2:0] = wd[2:0]; // see RQ13
                            end
                            st_nxt.p0_cfg[st_r.sel_pin][`SGPC_CFG_LOCK] =
                                st_r.p0_cfg[st_r.sel_pin][`SGPC_CFG_LOCK] | wd[3]; // see RQ13
                        end
                    end else if (sel_outonly(st_r.sel_port, st_r.sel_pin)) begin
                        if (!st_r.p1_cfg[st_r.sel_pin[0]][2]) begin
                            st_nxt.p1_cfg[st_r.sel_pin[0]][1:0] = wd[2:1]; // see RQ10
                        end
                        st_nxt.p1_cfg[st_r.sel_pin[0]][2] =
                            st_r.p1_cfg[st_r.sel_pin[0]][2] | wd[3]; // see RQ13
                    end
                end
                `SGPC_IDX_OUT_LATCH0: begin
                    for (int i = 0; i < `SGPC_BIDIR_PINS; i++) begin
                        if (!st_r.p0_cfg[i][`SGPC_CFG_LOCK]) begin
                            st_nxt.out0[i] = wd[i]; // see RQ19
                        end
                    end
                end
                `SGPC_IDX_OUT_LATCH1: begin
                    for (int i = 0; i < `SGPC_OUT_PINS; i++) begin
                        if (!st_r.p1_cfg[i][2]) begin
                            st_nxt.out1[i] = wd[i]; // see RQ19
                        end
                    end
                end
                `SGPC_IDX_PENDING: st_nxt.pend = st_r.pend & ~wd;
                default: ;
            endcase
        end

        // Software reset spares the lock and any locked output bit
        if (i_soft_reset) begin
            st_nxt.sel_port = 1'(`SGPC_SEL_RST >> `SGPC_SEL_PORT);
            st_nxt.sel_pin  = 3'(`SGPC_SEL_RST);
            for (int i = 0; i < `SGPC_BIDIR_PINS; i++) begin
                if (!st_r.p0_cfg[i][`SGPC_CFG_LOCK]) begin
                    st_nxt.out0[i] = 1'(`SGPC_OUT0_RST >> i);
                end
            end
            for (int i = 0; i < `SGPC_OUT_PINS; i++) begin
                if (!st_r.p1_cfg[i][2]) begin
                    st_nxt.out1[i] = 1'(`SGPC_OUT1_RST >> i);
                end
            end
        end // see RQ7

        // A new event beats a clear in the same cycle
        st_nxt.pend = st_nxt.pend | ev_hit; // see RQ20
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r          <= '0;
            st_r.p0_cfg   <= {8{`SGPC_CFG_P0_RST}}; // see RQ6, RQ14, RQ15, RQ16
            st_r.p1_cfg   <= {2{`SGPC_CFG_P1_RST}};
            st_r.out0     <= `SGPC_OUT0_RST;
            st_r.out1     <= `SGPC_OUT1_RST;
            st_r.prev     <= {8{`SGPC_PIN_IDLE}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Open-drain drives only a low level; push-pull drives both
    always_comb begin
        for (int i = 0; i < `SGPC_BIDIR_PINS; i++) begin
            o_pin0_out[i]    = st_r.out0[i];
            o_pin0_oe[i]     = st_r.p0_cfg[i][`SGPC_CFG_OE] &&
                               (st_r.p0_cfg[i][`SGPC_CFG_OTYPE] || !st_r.out0[i]); // see RQ15
            o_pin0_pullup[i] = st_r.p0_cfg[i][`SGPC_CFG_PULLUP]; // see RQ14
        end
        for (int i = 0; i < `SGPC_OUT_PINS; i++) begin
            o_pin1_out[i]    = st_r.out1[i];
            o_pin1_oe[i]     = st_r.p1_cfg[i][0] || !st_r.out1[i]; // see RQ16
            o_pin1_pullup[i] = st_r.p1_cfg[i][1];
        end
    end

    assign o_avs_readdata    = st_r.rdata;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_r.ack;
    assign o_event_pending   = st_r.pend;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_req;
        i_avs_read || i_avs_write;
    endsequence

    sequence s_win_read_done;
        i_avs_read && !o_avs_waitrequest && widx == `SGPC_IDX_SETUP_WIN;
    endsequence

    sequence s_fresh_diff;
        (st_r.p0_cfg[7][`SGPC_CFG_DBEN] && sync_q[7] == filt[7]) ##1
        (st_r.p0_cfg[7][`SGPC_CFG_DBEN] && sync_q[7] != filt[7]);
    endsequence

    AST_ANSWER_BOUND: assert property (s_req |-> ##[0:1] !o_avs_waitrequest) // see RQ11
        else $error("access not answered within one wait cycle");

    AST_WIN_RESERVED: assert property (s_win_read_done |-> o_avs_readdata[31:7] == 25'h0) // see RQ12
        else $error("setup window reserved bits not zero");

    AST_OUTONLY_OE: assert property (s_win_read_done ##0 (st_r.sel_port && st_r.sel_pin < 3'd2)
        |-> o_avs_readdata[7:0] == {4'h0, st_r.p1_cfg[st_r.sel_pin[0]], 1'b1}) // see RQ16
        else $error("output-only setup read wrong");

    AST_PLAIN_INPUT_ZERO: assert property (s_win_read_done ##0
        (st_r.sel_port && st_r.sel_pin >= 3'd2) |-> o_avs_readdata == 32'h0) // see RQ18
        else $error("plain input setup not zero");

    AST_INDEX_SOFT_RESET: assert property (i_soft_reset |=>
        !st_r.sel_port && st_r.sel_pin == 3'h0) // see RQ7
        else $error("pin index not cleared by soft reset");

    AST_LOCK_STICKY: assert property (($past(st_r.p1_cfg[0][2]) && !st_r.p1_cfg[0][2]) == 1'b0 &&
        ($past(st_r.p0_cfg[0][`SGPC_CFG_LOCK]) && !st_r.p0_cfg[0][`SGPC_CFG_LOCK]) == 1'b0) // see RQ13
        else $error("lock bit cleared");

    for (genvar ga = 0; ga < `SGPC_BIDIR_PINS; ga++) begin : g_ast
        AST_LOCK_FREEZE: assert property (st_r.p0_cfg[ga][`SGPC_CFG_LOCK] |=>
            $stable(st_r.p0_cfg[ga][2:0]) && $stable(st_r.out0[ga])) // see RQ13, RQ19
            else $error("locked pin changed");
    end

    AST_EVENT_SETS: assert property (ev_hit[6] |=> st_r.pend[6] ##1 $past(st_r.pend[6])) // see RQ20
        else $error("event did not set pending flag");

    AST_NO_SPURIOUS: assert property ((st_r.pend & ~$past(st_r.pend) & ~$past(ev_hit)) == 8'h0) // see RQ1
        else $error("pending set without a detected edge");

    AST_FALL_DEFAULT: assert property (!st_r.p0_cfg[6][`SGPC_CFG_EPOL] && $fell(filt[6])
        |-> ev_hit[6]) // see RQ2
        else $error("falling edge missed");

    AST_DEB_HOLD: assert property (s_fresh_diff |=> filt[7] == $past(filt[7])) // see RQ3, RQ4
        else $error("debounce passed a change at once");

    AST_DEB_BYPASS: assert property (!st_r.p0_cfg[6][`SGPC_CFG_DBEN]
        |=> filt[6] == $past(sync_q[6])) // see RQ6
        else $error("disabled debounce still delays");

    // Open-drain may only pull low; a high level comes from the pull-up
    for (genvar gb = 0; gb < `SGPC_BIDIR_PINS; gb++) begin : g_ast_od
        AST_OPEN_DRAIN_HIGH: assert property ( // see RQ15
            !st_r.p0_cfg[gb][`SGPC_CFG_OTYPE] && st_r.out0[gb] |-> !o_pin0_oe[gb])
            else $error("open-drain pin drove a high level");
    end

    AST_INDEX_WRITE: assert property ( // see RQ8, RQ9
        wr_go && widx == `SGPC_IDX_PIN_INDEX && !i_soft_reset
        |=> st_r.sel_pin == $past(wd[2:0]) && st_r.sel_port == $past(wd[4]))
        else $error("pin index write not taken");

    AST_INDEX_READ: assert property ( // see RQ9
        i_avs_read && !o_avs_waitrequest && widx == `SGPC_IDX_PIN_INDEX
        |-> o_avs_readdata[7:5] == 3'h0 && !o_avs_readdata[3])
        else $error("pin index reserved bits not zero");

    AST_WIN_BIDIR_READ: assert property ( // see RQ11
        s_win_read_done ##0 (!st_r.sel_port && st_r.sel_pin < 3'd6)
        |-> o_avs_readdata[6:0] == st_r.p0_cfg[st_r.sel_pin])
        else $error("bidirectional setup read wrong");

    AST_WIN_EVENT_LOW: assert property ( // see RQ12
        s_win_read_done ##0 (!st_r.sel_port && st_r.sel_pin >= 3'd6)
        |-> o_avs_readdata[3:0] == 4'h0)
        else $error("event-input pin shows output bits");

    // A clear without an event in flight must really clear
    AST_PEND_CLEAR: assert property ( // see RQ20
        wr_go && widx == `SGPC_IDX_PENDING
        |=> (st_r.pend & $past(wd) & ~$past(ev_hit)) == 8'h0)
        else $error("pending flag not cleared");

    AST_PEND_STICKY: assert property ( // see RQ20
        !(wr_go && widx == `SGPC_IDX_PENDING)
        |=> ($past(st_r.pend) & ~st_r.pend) == 8'h0)
        else $error("pending flag lost without a clear");

    AST_SOFT_LATCH: assert property ( // see RQ13
        i_soft_reset && !st_r.p0_cfg[1][`SGPC_CFG_LOCK] |=> st_r.out0[1])
        else $error("unlocked latch bit not restored by soft reset");

    AST_WRITE_MASKED: assert property ( // see RQ11
        i_avs_write && !o_avs_waitrequest && !i_avs_byteenable[0] && !i_soft_reset
        |=> st_r.sel_pin == $past(st_r.sel_pin) && st_r.out0 == $past(st_r.out0))
        else $error("write without low byte enable took effect");

endmodule // sgpc_top
`default_nettype wire

/* File: verif/test_sgpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgpc_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_sgpc_top;
    import sgpc_pkg::*;

    localparam int DB = 8;

    logic        i_clk;
    logic        i_resetn;
    logic        i_soft_reset;
    logic [7:0]  i_avs_address;
    logic        i_avs_read;
    logic        i_avs_write;
    logic [3:0]  i_avs_byteenable;
    sgpc_word_t  i_avs_writedata;
    sgpc_word_t  o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [7:0]  i_pin0_in;
    logic [5:0]  o_pin0_out;
    logic [5:0]  o_pin0_oe;
    logic [5:0]  o_pin0_pullup;
    logic [3:0]  i_pin1_in;
    logic [1:0]  o_pin1_out;
    logic [1:0]  o_pin1_oe;
    logic [1:0]  o_pin1_pullup;
    logic [7:0]  o_event_pending;
    logic [31:0] seed;
    logic [7:0]  rd;
    logic [7:0]  wv [16];
    int          err_count;
    int          checks;

    // Short debounce so the filter can be exercised in a few cycles
    sgpc_top #(.DEBOUNCE_CYCLES(DB)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_pin0_in(i_pin0_in), .o_pin0_out(o_pin0_out), .o_pin0_oe(o_pin0_oe),
        .o_pin0_pullup(o_pin0_pullup), .i_pin1_in(i_pin1_in), .o_pin1_out(o_pin1_out),
        .o_pin1_oe(o_pin1_oe), .o_pin1_pullup(o_pin1_pullup),
        .o_event_pending(o_event_pending)
    );

    always #2 i_clk = ~i_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Readback of the window for a given pin after writing w
    function automatic logic [7:0] cfg_exp(input logic port, input logic [2:0] pin,
                                           input logic [7:0] w);
        if (!port) begin
            return (pin < 3'd6) ? (w & 8'h7f) : (w & 8'h70);
        end
        return (pin < 3'd2) ? ((w & 8'h0e) | 8'h01) : 8'h00;
    endfunction

    task automatic results();
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Request is raised one edge after entry, so back-to-back calls never collide
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [11:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address    <= {idx, 2'b00};
        i_avs_write      <= wr;
        i_avs_read       <= ~wr;
        i_avs_writedata  <= {24'h0, wd};
        i_avs_byteenable <= 4'h1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        q = o_avs_readdata[11:0];
        if (n >= 50) begin
            err_count++;
        end
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [11:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [11:0] e);
        logic [11:0] d;
        bus(1'b0, idx, 8'h00, d);
        `CHK(d, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_soft_reset = 1'b0;
        i_avs_address = 8'h00;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_byteenable = 4'h0;
        i_avs_writedata = '0;
        i_pin0_in = 8'hff;
        i_pin1_in = 4'hf;
        seed = 32'd29;
        err_count = 0;
        checks = 0;
        tick(5);
        i_resetn <= 1'b1;
        tick(1);
        `CHK(o_pin0_oe, 6'h00)
        `CHK(o_pin0_pullup, 6'h3f)
        rd_chk(`SGPC_IDX_PIN_INDEX, 8'h00);
        rd_chk(`SGPC_IDX_OUT_LATCH0, 8'h3f);

        // Every port and pin: reset value, random write, readback; lock kept clear
        for (int i = 0; i < 16; i++) begin
            wr(`SGPC_IDX_PIN_INDEX, {3'b000, i[3], 1'b0, i[2:0]});
            rd_chk(`SGPC_IDX_SETUP_WIN, cfg_exp(i[3], i[2:0], 8'h44));
            wv[i] = xs() & 8'hf7;
            wr(`SGPC_IDX_SETUP_WIN, wv[i]);
            rd_chk(`SGPC_IDX_SETUP_WIN, cfg_exp(i[3], i[2:0], wv[i]));
        end
        rd_chk(`SGPC_IDX_PIN_INDEX, 8'h17);
        tick(1);
        for (int p = 0; p < 6; p++) begin
            `CHK(o_pin0_pullup[p], wv[p][2])
            `CHK(o_pin0_oe[p], wv[p][0] & wv[p][1])
        end
        for (int p = 0; p < 2; p++) begin
            `CHK(o_pin1_pullup[p], wv[8+p][2])
            `CHK(o_pin1_oe[p], wv[8+p][1])
        end

        // Unmapped place reads zero and still answers
        wr(6'h20, 8'hff);
        rd_chk(6'h20, 8'h00);

        // Readback of pin levels is unaffected by drive enables
        i_pin1_in <= 4'(xs());
        tick(4);
        rd_chk(`SGPC_IDX_PIN_LEVEL, {i_pin1_in, i_pin0_in});

        // Lock on port 0 pin 0: low nibble and latch bit freeze, event bits stay writable
        wr(`SGPC_IDX_PIN_INDEX, 8'h00);
        wr(`SGPC_IDX_SETUP_WIN, 8'h0f);
        wr(`SGPC_IDX_SETUP_WIN, 8'h70);
        rd_chk(`SGPC_IDX_SETUP_WIN, 8'h7f);
        wr(`SGPC_IDX_OUT_LATCH0, 8'h00);
        rd_chk(`SGPC_IDX_OUT_LATCH0, 8'h01);
        `CHK(o_pin0_out, 6'h01)
        @(posedge i_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_clk);
        i_soft_reset <= 1'b0;
        rd_chk(`SGPC_IDX_PIN_INDEX, 8'h00);
        rd_chk(`SGPC_IDX_OUT_LATCH0, 8'h3f);
        wr(`SGPC_IDX_SETUP_WIN, 8'h00);
        rd_chk(`SGPC_IDX_SETUP_WIN, 8'h0f);

        // Port 0 pin 6, no debounce: falling edge detected, then rising with polarity and type bits set
        wr(`SGPC_IDX_PIN_INDEX, 8'h06);
        wr(`SGPC_IDX_SETUP_WIN, 8'h00);
        tick(4);
        i_pin0_in[6] <= 1'b0;
        tick(2);
        `CHK(o_event_pending[6], 1'b0)
        tick(6);
        `CHK(o_event_pending[6], 1'b1)
        rd_chk(`SGPC_IDX_PENDING, 8'h40);
        wr(`SGPC_IDX_PENDING, 8'h40);
        rd_chk(`SGPC_IDX_PENDING, 8'h00);
        wr(`SGPC_IDX_SETUP_WIN, 8'h30);
        i_pin0_in[6] <= 1'b1;
        tick(8);
        `CHK(o_event_pending, 8'h40)
        wr(`SGPC_IDX_PENDING, 8'h40);
        i_pin0_in[6] <= 1'b0;
        tick(8);
        `CHK(o_event_pending, 8'h00)

        // Port 0 pin 7 with debounce: short glitch filtered, long low delayed
        wr(`SGPC_IDX_PIN_INDEX, 8'h07);
        wr(`SGPC_IDX_SETUP_WIN, 8'h40);
        tick(4);
        i_pin0_in[7] <= 1'b0;
        tick(DB / 2);
        i_pin0_in[7] <= 1'b1;
        tick(3 * DB);
        `CHK(o_event_pending[7], 1'b0)
        i_pin0_in[7] <= 1'b0;
        tick(6);
        `CHK(o_event_pending[7], 1'b0)
        tick(3 * DB);
        `CHK(o_event_pending[7], 1'b1)
        wr(`SGPC_IDX_PENDING, 8'h80);
        i_pin0_in[7] <= 1'b1;
        tick(3 * DB);
        `CHK(o_event_pending, 8'h00)
        results();
    end
endmodule // test_sgpc_top
`default_nettype wire
